// ===== hw/owb_top.sv
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - Write-byte command with one data byte sends that byte on the wire.
// - Write-byte while busy is refused, code and data both, and dropped.
// - Write-byte lasts eight slot periods plus a short start latency.
// - Slots start after the whole byte arrives, within the start latency.
// - Accepting either byte command points reads at the status.
// - Busy flag stays set through all eight slots.
// - Read-byte makes eight read slots and stores the byte.
// - Read-byte while busy is refused and ignored.
// - Read slots start within the latency and end after eight slots.
// - Each read slot is a write-one slot whose level is sampled.
// - The line is sampled at the master sample time.
module owb_top import owb_pkg::*; (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        link_clk,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        line_i,
  output logic             line_o,
  output logic             line_oe_n,
  output logic             strong_pullup_on
);
  // ****************************************
  // Bus-side state
  // ****************************************
  typedef struct packed {
    owb_cs_e    st;
    logic       is_rd;
    logic [7:0] wdata;
    logic [2:0] xcfg;
    logic       req_tgl;
    logic [7:0] rdata;
    logic       rptr;
    logic [2:0] cfg;
    logic       ack;
    logic       err;
    logic [7:0] dat;
  } owb_cs_s;

  // ****************************************
  // Link-side state
  // ****************************************
  typedef struct packed {
    owb_ls_e              st;
    logic [OWB_CNT_W-1:0] cnt;
    logic [2:0]           bitn;
    logic [7:0]           sh;
    logic                 one;
    logic                 samp;
    logic                 rd;
    logic                 active_pullup_enable;
    logic                 strong_pullup_enable;
    logic                 spd;
    logic                 done_tgl;
    logic                 lo;
    logic                 oe_n;
  } owb_ls_s;

  owb_cs_s c_reg;
  owb_cs_s c_next;
  owb_ls_s l_reg;
  owb_ls_s l_next;

  logic       wb_req;
  logic       busy;
  logic [7:0] code;
  logic [7:0] param;
  logic       done_pulse;
  logic       req_pulse;
  logic       rst_l;
  logic       ce_l;
  logic       line_s;

  // ****************************************
  // Crossings
  // ****************************************
  // Reset, enable and the wire level into the link domain
  owb_sync2 #(.W(3)) u_sync_link (
    .clk (link_clk),
    .d   ({srst, ce, line_i}),
    .q   ({rst_l, ce_l, line_s})
  );

  // Command start: data and config are held steady before the toggle
  owb_tgl_sync u_req_sync (
    .clk   (link_clk),
    .rst   (rst_l),
    .en    (ce_l),
    .tgl   (c_reg.req_tgl),
    .pulse (req_pulse)
  );

  // Command end: the shifted byte stays put until the next start
  owb_tgl_sync u_done_sync (
    .clk   (clk),
    .rst   (srst),
    .en    (ce),
    .tgl   (l_reg.done_tgl),
    .pulse (done_pulse)
  );

  // ****************************************
  // Wishbone slave and command decode
  // ****************************************
  // Single-cycle answer; the request is masked while ack or err stands
  assign wb_req = wb_cyc_i & wb_stb_i & ~c_reg.ack & ~c_reg.err;
  assign busy   = (c_reg.st == OWB_CS_BUSY);
  assign code   = wb_dat_i[OWB_CODE_LSB +: 8];
  assign param  = wb_dat_i[OWB_PARAM_LSB +: 8];

  // Next bus-side state
  always_comb begin
    c_next     = c_reg;
    c_next.ack = 1'b0;
    c_next.err = 1'b0;
    if (done_pulse) begin
      c_next.st = OWB_CS_IDLE;
      if (c_reg.is_rd) begin
        c_next.rdata = l_reg.sh;
      end
    end
    if (wb_req) begin
      c_next.ack = 1'b1;
      c_next.dat = OWB_BYTE_RST;
      case (wb_adr_i)
        OWB_ADR_CMD: begin
          if (!wb_we_i) begin
            c_next.ack = 1'b1;
          end else if (code == OWB_CMD_WRB || code == OWB_CMD_RDB) begin
            if (busy) begin
              c_next.ack = 1'b0;
              c_next.err = 1'b1;
            end else begin
              c_next.st      = OWB_CS_BUSY;
              c_next.is_rd   = (code == OWB_CMD_RDB);
              c_next.wdata   = param;
              c_next.req_tgl = ~c_reg.req_tgl;
              c_next.xcfg    = c_reg.cfg;
              if (code == OWB_CMD_RDB) begin
                c_next.xcfg[OWB_CFG_SPU] = 1'b0;
              end
              c_next.rptr = OWB_PTR_STAT;
            end
          end else if (code == OWB_CMD_PTR && param == OWB_PTR_STAT_CODE) begin
            c_next.rptr = OWB_PTR_STAT;
          end else if (code == OWB_CMD_PTR && param == OWB_PTR_RDAT_CODE) begin
            c_next.rptr = OWB_PTR_RDAT;
          end else begin
            c_next.ack = 1'b0;
            c_next.err = 1'b1;
          end
        end
        OWB_ADR_DATA: begin
          if (c_reg.rptr == OWB_PTR_RDAT) begin
            c_next.dat = c_reg.rdata;
          end else begin
            c_next.dat = {7'h00, busy};
          end
        end
        OWB_ADR_CFG: begin
          if (wb_we_i && wb_sel_i[0]) begin
            c_next.cfg = wb_dat_i[2:0];
          end
          c_next.dat = {5'h00, c_reg.cfg};
        end
        default: begin
          c_next.ack = 1'b0;
          c_next.err = 1'b1;
        end
      endcase
    end
  end

  // Bus-side register
  always_ff @(posedge clk) begin
    if (srst) begin
      c_reg.st      <= OWB_CS_IDLE;
      c_reg.is_rd   <= 1'b0;
      c_reg.wdata   <= OWB_BYTE_RST;
      c_reg.xcfg    <= OWB_CFG_RST;
      c_reg.req_tgl <= 1'b0;
      c_reg.rdata   <= OWB_BYTE_RST;
      c_reg.rptr    <= OWB_PTR_STAT;
      c_reg.cfg     <= OWB_CFG_RST;
      c_reg.ack     <= 1'b0;
      c_reg.err     <= 1'b0;
      c_reg.dat     <= OWB_BYTE_RST;
    end else if (ce) begin
      c_reg <= c_next;
    end
  end

  assign wb_ack_o = c_reg.ack;
  assign wb_err_o = c_reg.err;
  assign wb_dat_o = {24'h000000, c_reg.dat};

  // ****************************************
  // Slot engine on the link clock
  // ****************************************
  logic [OWB_CNT_W-1:0] slot_c;
  logic [OWB_CNT_W-1:0] msr_c;
  logic [OWB_CNT_W-1:0] w1l_c;

  // Times for the speed of the running command
  assign slot_c = l_reg.spd ? OWB_OD_SLOT_CYC : OWB_STD_SLOT_CYC;
  assign msr_c  = l_reg.spd ? OWB_OD_MSR_CYC : OWB_STD_MSR_CYC;
  assign w1l_c  = l_reg.spd ? OWB_OD_W1L_CYC : OWB_STD_W1L_CYC;

  // Next link-side state; pin drive is planned one cycle ahead
  always_comb begin
    logic [OWB_CNT_W-1:0] low_n;
    logic [OWB_CNT_W-1:0] apu_n;
    low_n  = OWB_STD_W0L_CYC;
    apu_n  = OWB_STD_APU_CYC;
    l_next = l_reg;
    if (req_pulse) begin
      // start once the byte is whole
      l_next.st   = OWB_LS_SLOT;
      l_next.cnt  = '0;
      l_next.bitn = 3'h0;
      l_next.sh   = c_reg.wdata;
      l_next.rd   = c_reg.is_rd;
      l_next.active_pullup_enable  = c_reg.xcfg[OWB_CFG_APU];
      l_next.strong_pullup_enable  = c_reg.xcfg[OWB_CFG_SPU];
      l_next.spd  = c_reg.xcfg[OWB_CFG_SPD];
      l_next.one  = c_reg.is_rd | c_reg.wdata[0];
    end else begin
      unique case (l_reg.st)
        OWB_LS_IDLE: begin
          l_next.st = OWB_LS_IDLE;
        end
        OWB_LS_STRONG: begin
          l_next.st = OWB_LS_STRONG;
        end
        OWB_LS_SLOT: begin
          l_next.cnt = l_reg.cnt + 1'b1;
          if (l_reg.cnt == msr_c - 1'b1) begin
            l_next.samp = line_s;
          end
          if (l_reg.cnt == slot_c - 1'b1) begin
            l_next.cnt  = '0;
            l_next.sh   = {l_reg.samp, l_reg.sh[7:1]};
            l_next.one  = l_reg.rd | l_reg.sh[1];
            l_next.bitn = l_reg.bitn + 1'b1;
            if (l_reg.bitn == OWB_LAST_BIT) begin
              l_next.done_tgl = ~l_reg.done_tgl;
              l_next.st = l_reg.strong_pullup_enable ? OWB_LS_STRONG : OWB_LS_IDLE;
            end
          end
        end
      endcase
    end
    if (l_next.spd) begin
      low_n = l_next.one ? OWB_OD_W1L_CYC : OWB_OD_W0L_CYC;
      apu_n = OWB_OD_APU_CYC;
    end else begin
      low_n = l_next.one ? OWB_STD_W1L_CYC : OWB_STD_W0L_CYC;
    end
    // Released line by default; active pullup pushes the rising edge
    l_next.lo   = 1'b1;
    l_next.oe_n = 1'b1;
    if (l_next.st == OWB_LS_STRONG) begin
      l_next.oe_n = 1'b0;
    end else if (l_next.st == OWB_LS_SLOT) begin
      if (l_next.cnt < low_n) begin
        l_next.lo   = 1'b0;
        l_next.oe_n = 1'b0;
      end else if (l_next.active_pullup_enable && (l_next.cnt < low_n + apu_n)) begin
        l_next.oe_n = 1'b0;
      end
    end
  end

  // Link-side register
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      l_reg.st       <= OWB_LS_IDLE;
      l_reg.cnt      <= '0;
      l_reg.bitn     <= 3'h0;
      l_reg.sh       <= OWB_BYTE_RST;
      l_reg.one      <= 1'b0;
      l_reg.samp     <= 1'b0;
      l_reg.rd       <= 1'b0;
      l_reg.active_pullup_enable      <= 1'b0;
      l_reg.strong_pullup_enable      <= 1'b0;
      l_reg.spd      <= 1'b0;
      l_reg.done_tgl <= 1'b0;
      l_reg.lo       <= 1'b1;
      l_reg.oe_n     <= 1'b1;
    end else if (ce_l) begin
      l_reg <= l_next;
    end
  end

  assign line_o           = l_reg.lo;
  assign line_oe_n        = l_reg.oe_n;
  assign strong_pullup_on = (l_reg.st == OWB_LS_STRONG);

  // ****************************************
  // Assertions
  // ****************************************
  AST_WRB_LAUNCH: assert property (
    @(posedge clk) disable iff (srst)
    ce && wb_req && wb_we_i && wb_adr_i == OWB_ADR_CMD && code == OWB_CMD_WRB && !busy
    |=> busy && wb_ack_o && c_reg.wdata == $past(param)
        && c_reg.req_tgl != $past(c_reg.req_tgl))
    else $error("write byte not launched");

  AST_WRB_REFUSE: assert property (
    @(posedge clk) disable iff (srst)
    ce && wb_req && wb_we_i && wb_adr_i == OWB_ADR_CMD && code == OWB_CMD_WRB && busy
    |=> wb_err_o && !wb_ack_o && $stable(c_reg.req_tgl) && $stable(c_reg.wdata))
    else $error("busy write byte not refused");

  AST_RDB_REFUSE: assert property (
    @(posedge clk) disable iff (srst)
    ce && wb_req && wb_we_i && wb_adr_i == OWB_ADR_CMD && code == OWB_CMD_RDB && busy
    |=> wb_err_o && $stable(c_reg.req_tgl))
    else $error("busy read byte not refused");

  AST_PTR_STATUS: assert property (
    @(posedge clk) disable iff (srst)
    ce && wb_req && wb_we_i && wb_adr_i == OWB_ADR_CMD && code == OWB_CMD_RDB && !busy
    |=> c_reg.rptr == OWB_PTR_STAT && busy && c_reg.is_rd)
    else $error("pointer not on status after read byte");

  AST_BUSY_HOLD: assert property (
    @(posedge clk) disable iff (srst)
    $fell(busy) |-> $past(done_pulse))
    else $error("busy dropped before the slots ended");

  AST_RDATA_LOAD: assert property (
    @(posedge clk) disable iff (srst)
    ce && done_pulse && c_reg.is_rd |=> c_reg.rdata == $past(l_reg.sh) && !busy)
    else $error("read byte not stored");

  AST_RDATA_STABLE: assert property (
    @(posedge clk) disable iff (srst)
    busy && !done_pulse |=> $stable(c_reg.rdata))
    else $error("read data moved mid command");

  AST_WR_START: assert property (
    @(posedge link_clk) disable iff (rst_l)
    ce_l && req_pulse && !c_reg.is_rd
    |=> l_reg.st == OWB_LS_SLOT && !line_oe_n && !line_o ##1 l_reg.cnt == 1)
    else $error("write slots did not start");

  AST_RD_START: assert property (
    @(posedge link_clk) disable iff (rst_l)
    ce_l && req_pulse && c_reg.is_rd |=> l_reg.st == OWB_LS_SLOT && !line_oe_n && l_reg.rd)
    else $error("read slots did not start");

  AST_SLOT_BOUND: assert property (
    @(posedge link_clk) disable iff (rst_l)
    l_reg.st == OWB_LS_SLOT |-> l_reg.cnt < slot_c)
    else $error("slot counter overran");

  AST_READ_ONE: assert property (
    @(posedge link_clk) disable iff (rst_l)
    l_reg.st == OWB_LS_SLOT && l_reg.rd && l_reg.cnt >= w1l_c |-> line_oe_n || line_o)
    else $error("read slot held the line low");

  AST_SAMPLE: assert property (
    @(posedge link_clk) disable iff (rst_l)
    ce_l && l_reg.st == OWB_LS_SLOT && l_reg.cnt == msr_c - 1'b1
    |=> l_reg.samp == $past(line_s))
    else $error("line not sampled at master time");

  AST_SPU_DRIVE: assert property (
    @(posedge link_clk) disable iff (rst_l)
    strong_pullup_on |-> !line_oe_n && line_o && l_reg.strong_pullup_enable)
    else $error("strong pullup not driving high");

  AST_SPU_NOREAD: assert property (
    @(posedge link_clk) disable iff (rst_l)
    l_reg.st == OWB_LS_STRONG |-> !l_reg.rd)
    else $error("strong pullup after a read");

  COV_WRB_DONE: cover property (
    @(posedge clk) disable iff (srst) done_pulse && !c_reg.is_rd);
  COV_RDB_DONE: cover property (
    @(posedge clk) disable iff (srst) done_pulse && c_reg.is_rd);
  COV_REFUSED: cover property (
    @(posedge clk) disable iff (srst) busy && wb_err_o);
  COV_STRONG: cover property (
    @(posedge link_clk) disable iff (rst_l) strong_pullup_on);
endmodule // owb_top

// ===== hw/owb_pkg.sv
package owb_pkg;
  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [3:0] OWB_ADR_CMD  = 4'h0;
  localparam logic [3:0] OWB_ADR_DATA = 4'h4;
  localparam logic [3:0] OWB_ADR_CFG  = 4'h8;
  localparam int OWB_CODE_LSB  = 0;
  localparam int OWB_PARAM_LSB = 8;
  localparam int OWB_CFG_APU   = 0;
  localparam int OWB_CFG_SPU   = 1;
  localparam int OWB_CFG_SPD   = 2;
  localparam logic [2:0] OWB_CFG_RST  = 3'h0;
  localparam logic [7:0] OWB_BYTE_RST = 8'h00;
  localparam logic       OWB_PTR_STAT = 1'b0;
  localparam logic       OWB_PTR_RDAT = 1'b1;
  localparam logic [7:0] OWB_PTR_STAT_CODE = 8'h00;
  localparam logic [7:0] OWB_PTR_RDAT_CODE = 8'h01;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] OWB_CMD_WRB = 8'ha5;
  localparam logic [7:0] OWB_CMD_RDB = 8'h96;
  localparam logic [7:0] OWB_CMD_PTR = 8'hc3;

  // ****************************************
  // Slot timing, link clock cycles
  // ****************************************
  localparam int OWB_LINK_NS     = 48;
  localparam int OWB_CNT_W       = 12;
  localparam int OWB_STD_SLOT_NS = 70000;
  localparam int OWB_STD_W0L_NS  = 60000;
  localparam int OWB_STD_W1L_NS  = 8000;
  localparam int OWB_STD_MSR_NS  = 15000;
  localparam int OWB_STD_APU_NS  = 2000;
  localparam int OWB_OD_SLOT_NS  = 10000;
  localparam int OWB_OD_W0L_NS   = 8000;
  localparam int OWB_OD_W1L_NS   = 1000;
  localparam int OWB_OD_MSR_NS   = 2000;
  localparam int OWB_OD_APU_NS   = 500;

  // Least times, so round up to whole link cycles
  function automatic logic [OWB_CNT_W-1:0] owb_cyc(input int ns);
    return OWB_CNT_W'((ns + OWB_LINK_NS - 1) / OWB_LINK_NS);
  endfunction

  localparam logic [OWB_CNT_W-1:0] OWB_STD_SLOT_CYC = owb_cyc(OWB_STD_SLOT_NS);
  localparam logic [OWB_CNT_W-1:0] OWB_STD_W0L_CYC  = owb_cyc(OWB_STD_W0L_NS);
  localparam logic [OWB_CNT_W-1:0] OWB_STD_W1L_CYC  = owb_cyc(OWB_STD_W1L_NS);
  localparam logic [OWB_CNT_W-1:0] OWB_STD_MSR_CYC  = owb_cyc(OWB_STD_MSR_NS);
  localparam logic [OWB_CNT_W-1:0] OWB_STD_APU_CYC  = owb_cyc(OWB_STD_APU_NS);
  localparam logic [OWB_CNT_W-1:0] OWB_OD_SLOT_CYC  = owb_cyc(OWB_OD_SLOT_NS);
  localparam logic [OWB_CNT_W-1:0] OWB_OD_W0L_CYC   = owb_cyc(OWB_OD_W0L_NS);
  localparam logic [OWB_CNT_W-1:0] OWB_OD_W1L_CYC   = owb_cyc(OWB_OD_W1L_NS);
  localparam logic [OWB_CNT_W-1:0] OWB_OD_MSR_CYC   = owb_cyc(OWB_OD_MSR_NS);
  localparam logic [OWB_CNT_W-1:0] OWB_OD_APU_CYC   = owb_cyc(OWB_OD_APU_NS);
  localparam logic [2:0] OWB_LAST_BIT = 3'h7;

  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [1:0] {
    OWB_CS_IDLE = 2'b01,
    OWB_CS_BUSY = 2'b10
  } owb_cs_e;

  typedef enum logic [2:0] {
    OWB_LS_IDLE   = 3'b001,
    OWB_LS_SLOT   = 3'b010,
    OWB_LS_STRONG = 3'b100
  } owb_ls_e;
endpackage

// ===== hw/owb_sync2.sv
`timescale 1ns/1ns
// Two-stage level synchroniser; no reset so it also carries reset
module owb_sync2 import owb_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } owb_sy_s;

  owb_sy_s sy_reg;
  owb_sy_s sy_next;

  // Stage one feeds stage two only
  always_comb begin
    sy_next.s1 = d;
    sy_next.s2 = sy_reg.s1;
  end

  always_ff @(posedge clk) begin
    sy_reg <= sy_next;
  end

  assign q = sy_reg.s2;
endmodule // owb_sync2

// ===== hw/owb_tgl_sync.sv
`timescale 1ns/1ns
// Toggle-to-pulse crossing; frozen with the enable so no event is lost
module owb_tgl_sync import owb_pkg::*; (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  input  wire logic tgl,
  output logic      pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } owb_ts_s;

  owb_ts_s ts_reg;
  owb_ts_s ts_next;

  // Shift the toggle through three stages
  always_comb begin
    ts_next.s1 = tgl;
    ts_next.s2 = ts_reg.s1;
    ts_next.s3 = ts_reg.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ts_reg <= '0;
    end else if (en) begin
      ts_reg <= ts_next;
    end
  end

  // Edge of the settled stages only
  assign pulse = en & (ts_reg.s2 ^ ts_reg.s3);
endmodule // owb_tgl_sync

// ===== tb/owb_slave_model.sv
`timescale 1ns/1ns
// ****************************************
// Behavioural wire slave
// ****************************************
module owb_slave_model (
  input  wire logic       wire_i,
  input  wire logic [7:0] tx_byte,
  output logic            pull_low,
  output logic [7:0]      rx_byte
);
  logic [2:0] idx;

  // Quiet line and empty receive register from the start
  initial begin
    pull_low = 1'b0;
    rx_byte = 8'h00;
    idx = 3'h0;
  end

  // Every master low opens a slot; sampling late keeps a zero visible
  // zero pulls, one never
  always @(negedge wire_i) begin
    pull_low = ~tx_byte[idx];
    #3000;
    rx_byte = {wire_i, rx_byte[7:1]};
    pull_low = 1'b0;
    idx = idx + 3'h1;
  end
endmodule // owb_slave_model

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench import owb_pkg::*; ;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, srst, link_clk, wb_cyc, wb_stb, wb_we;
  logic [3:0]  wb_adr;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_ack_o, wb_err_o, line_o, line_oe_n, spu_on, line_w, pull_low;
  logic [7:0]  rx_byte, tx_byte;
  int          n_fail, n_checks, cyc_n, t0, t1, k;
  localparam int DUR = 8 * OWB_OD_SLOT_CYC * OWB_LINK_NS / 10;

  // Wire is pulled up; any low driver wins
  assign line_w = ~pull_low & (line_oe_n | line_o);

  owb_top u_dut (.clk(clk), .srst(srst), .ce(1'b1), .link_clk(link_clk),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .line_i(line_w), .line_o(line_o), .line_oe_n(line_oe_n),
    .strong_pullup_on(spu_on));

  owb_slave_model u_slave (.wire_i(line_w), .tx_byte(tx_byte), .pull_low(pull_low),
    .rx_byte(rx_byte));

  // Clocks; link clock offset by 7 ns so the rising edges line up only once every 240 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge clk) cyc_n <= cyc_n + 1;

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle; request held until ack or err is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    e = (wb_err_o === 1'b1);
    if (n >= 20) n_fail++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic        e;
    wb(1'b1, a, d, q, e);
    chk("write error", {31'h0, ee}, {31'h0, e});
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic ee);
    logic [31:0] q;
    logic        e;
    wb(1'b0, a, 32'h0, q, e);
    chk("read error", {31'h0, ee}, {31'h0, e});
    if (!ee) chk("read data", x, q);
  endtask

  // Poll status until busy clears; bounded by the poll count
  task automatic wait_idle(output int t);
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    do begin
      wb(1'b0, OWB_ADR_DATA, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 20000);
    if (n >= 20000) n_fail++;
    t = cyc_n;
  endtask

  task automatic ptr(input logic [7:0] p);
    wr(OWB_ADR_CMD, {16'h0, p, OWB_CMD_PTR}, 1'b0);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard: five byte operations need about 41000 cycles
  initial begin
    #600000;
    n_fail++;
    end_sim;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_i} = '0;
    srst = 1'b1;
    tx_byte = 8'hff;
    n_fail = 0;
    n_checks = 0;
    cyc_n = 0;
    // Long reset so the link side sees it too
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    rd(OWB_ADR_CFG, 32'h0, 1'b0);
    rd(OWB_ADR_DATA, 32'h0, 1'b0);
    rd(4'hc, 32'h0, 1'b1);
    $display("test reset done");
    // Fast speed with active pullup, then a write byte and a read byte refused mid-run
    wr(OWB_ADR_CFG, 32'h5, 1'b0);
    wr(OWB_ADR_CMD, 32'h3ca5, 1'b0);
    t0 = cyc_n;
    k = 0;
    while (line_oe_n !== 1'b0 && k < 60) begin
      @(posedge clk);
      k++;
    end
    chk("start latency", 32'h1, 32'(k <= 26));
    wr(OWB_ADR_CMD, 32'h55a5, 1'b1);
    wr(OWB_ADR_CMD, 32'h0096, 1'b1);
    rd(OWB_ADR_DATA, 32'h1, 1'b0);
    wait_idle(t1);
    chk("write time", 32'h1, 32'(t1 - t0 >= DUR && t1 - t0 <= DUR + 60));
    chk("slave byte", 32'h3c, {24'h0, rx_byte});
    $display("test write byte done");
    // Read byte; old read data stays until the slots end
    tx_byte <= 8'ha6;
    wr(OWB_ADR_CMD, 32'h0096, 1'b0);
    t0 = cyc_n;
    ptr(OWB_PTR_RDAT_CODE);
    rd(OWB_ADR_DATA, 32'h0, 1'b0);
    ptr(OWB_PTR_STAT_CODE);
    wait_idle(t1);
    chk("read time", 32'h1, 32'(t1 - t0 >= DUR && t1 - t0 <= DUR + 60));
    ptr(OWB_PTR_RDAT_CODE);
    rd(OWB_ADR_DATA, 32'ha6, 1'b0);
    $display("test read byte done");
    // Strong pullup follows a write but never a read
    tx_byte <= 8'hff;
    wr(OWB_ADR_CFG, 32'h6, 1'b0);
    wr(OWB_ADR_CMD, 32'h81a5, 1'b0);
    rd(OWB_ADR_DATA, 32'h1, 1'b0);
    wait_idle(t1);
    chk("strong pullup", 32'h1, {31'h0, spu_on});
    chk("slave byte", 32'h81, {24'h0, rx_byte});
    tx_byte <= 8'h5a;
    wr(OWB_ADR_CMD, 32'h0096, 1'b0);
    repeat (40) @(posedge clk);
    chk("strong pullup", 32'h0, {31'h0, spu_on});
    wait_idle(t1);
    chk("strong pullup", 32'h0, {31'h0, spu_on});
    ptr(OWB_PTR_RDAT_CODE);
    rd(OWB_ADR_DATA, 32'h5a, 1'b0);
    $display("test pullup done");
    // Reset after a write ends while the strong pullup holds the line
    wr(OWB_ADR_CMD, 32'h00a5, 1'b0);
    wait_idle(t1);
    chk("strong pullup", 32'h1, {31'h0, spu_on});
    srst <= 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    chk("strong pullup", 32'h0, {31'h0, spu_on});
    rd(OWB_ADR_CFG, 32'h0, 1'b0);
    rd(OWB_ADR_DATA, 32'h0, 1'b0);
    $display("test mid reset done");
    end_sim;
  end
endmodule // testbench
